// ### hdl/dmapri_core.sv
// Demand-mode DMA sequencer with two cascaded four-channel priority groups.
// Assumes synchronous inputs, a host that answers the hold request, and a
// register master that reads data one cycle after the read strobe.
//
// What this block does
// R1 - Demand transfer runs until count expiry or end
// R2 - Request sampled only in requester accesses
// R3 - On drop, finish transfer, release, keep state
// R4 - Reasserted request rearbitrates and resumes saved state
// R5 - First access two states after hold acknowledge
// R6 - Release bus one state after request drops
// R7 - Auto-init reload takes seven states holding bus
// R8 - Requester-source two-cycle adds two idle states
// R9 - Lower group is one slot between 7, 4
// R10 - Each group fixed or rotating independently
// R11 - Default fixed order channel 0 to 7
// R12 - Grant highest priority requesting channel
// R13 - Command sets lowest channel, next becomes highest
// R14 - Lowest-priority command ignored while group rotates
// R15 - Mode switches keep or restore programmed order
// R16 - Serviced channel becomes lowest in rotating group
// R17 - Lower service also rotates upper around slot
// R18 - Per-channel fly-by, widths, direction via software
// R19 - Hold request one state after service request
// R20 - Arbitrate in first state after acknowledge
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module dmapri_core #(
    parameter int CNT_W = 16
) (
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    input  wire logic [dmapri_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [dmapri_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [dmapri_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [dmapri_pkg::NCH-1:0]    channel_service_request,
    input  wire logic                          end_of_process_n,
    input  wire logic                          bus_hold_acknowledge,
    output logic                               bus_hold_request,
    output logic      [dmapri_pkg::NCH-1:0]    channel_ack,
    output logic                               requester_access,
    output logic                               target_access,
    output logic                               cycle_flyby,
    output logic                               cycle_write,
    output logic      [1:0]                    requester_width,
    output logic      [1:0]                    target_width
);
    import dmapri_pkg::*;

    dmapri_state_t      state_q;
    dmapri_state_t      state_d;
    logic [1:0]         mode_q;
    logic [1:0]         prog_lo_q;
    logic [1:0]         cur_lo_q;
    logic [2:0]         prog_up_q;
    logic [2:0]         cur_up_q;
    logic [7:0]         cfg_q   [NCH];
    logic [CNT_W-1:0]   base_q  [NCH];
    logic [CNT_W-1:0]   cnt_q   [NCH];
    logic [2:0]         chsel_q;
    logic [2:0]         act_q;
    logic [NCH-1:0]     done_q;
    logic [TMR_W-1:0]   tmr_q;
    logic               hold_q;
    logic               end_q;
    logic               drop_q;
    logic [DATA_W-1:0]  rdata_q;
    logic [NCH-1:0]     en_vec;

    // Register decode
    wire wr_mode  = reg_wr && (reg_addr == REG_MODE);
    wire wr_prio  = reg_wr && (reg_addr == REG_PRIO);
    wire wr_stat  = reg_wr && (reg_addr == REG_STAT);
    wire wr_chsel = reg_wr && (reg_addr == REG_CHSEL);
    wire wr_chcfg = reg_wr && (reg_addr == REG_CHCFG);
    wire wr_count = reg_wr && (reg_addr == REG_COUNT);

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            en_vec[i] = cfg_q[i][CFG_EN];
        end
    end

    // Lowest-priority pointers per group
    // R15 restore programmed order
    wire [1:0] lo_low = mode_q[MODE_LO_ROT] ? cur_lo_q : prog_lo_q;
    wire [2:0] up_low = mode_q[MODE_UP_ROT] ? cur_up_q : prog_up_q;
    wire [NCH-1:0] pend = channel_service_request & en_vec;

    // R13 cyclic order after lowest
    function automatic logic [2:0] pick4(input logic [3:0] r, input logic [1:0] low);
        logic [2:0] res;
        logic [1:0] i;
        res = 3'h0;
        for (int k = 4; k >= 1; k--) begin
            i = 2'(low + 2'(k));
            if (r[i]) begin
                res = {1'b1, i};
            end
        end
        return res;
    endfunction

    function automatic logic [3:0] pick5(input logic [4:0] r, input logic [2:0] low);
        logic [3:0] res;
        logic [2:0] i;
        res = 4'h0;
        for (int k = 5; k >= 1; k--) begin
            i = 3'((int'(low) + k) % 5);
            if (r[i]) begin
                res = {1'b1, i};
            end
        end
        return res;
    endfunction

    // R9 lower group as slot four
    // R12 highest requesting channel wins
    wire [2:0] lo_pick   = pick4(pend[3:0], lo_low);
    wire [3:0] up_pick   = pick5({lo_pick[2], pend[7:4]}, up_low);
    wire       win_valid = up_pick[3];
    wire       win_lo    = (up_pick[2:0] == LO_SLOT);
    wire [2:0] win_ch    = win_lo ? {1'b0, lo_pick[1:0]} : {1'b1, up_pick[1:0]};

    // Active channel attributes
    // R18 per-channel cycle options
    wire [7:0] act_cfg  = cfg_q[act_q];
    wire       a_flyby  = act_cfg[CFG_FLYBY];
    wire       a_write  = act_cfg[CFG_WRITE];
    wire       a_auto   = act_cfg[CFG_AUTO];
    wire       idle_need = a_write && !a_flyby;
    wire       tc_now   = (cnt_q[act_q] == '0);
    wire       req_now  = channel_service_request[act_q];

    // R2 request only seen in requester access
    wire in_racc  = (state_q == S_RACC);
    wire fin_now  = (in_racc && (a_flyby || !a_write)) || ((state_q == S_TACC) && idle_need);
    wire ended    = in_racc ? (tc_now || !end_of_process_n) : end_q;
    wire dropped  = in_racc ? !req_now : drop_q;
    wire first_acc = (a_flyby || a_write);
    wire tmr_zero = (tmr_q == '0);

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                // R19 hold one state after request
                if (|pend) begin
                    state_d = S_HOLD;
                end
            end
            S_HOLD: begin
                // R20 arbitrate after acknowledge
                if (bus_hold_acknowledge) begin
                    state_d = S_ARB;
                end
            end
            S_ARB: begin
                // R4 restart rearbitrated, count kept
                // R5 first access follows arbitration
                if (!win_valid) begin
                    state_d = S_REL;
                end else if (cfg_q[win_ch][CFG_FLYBY] || cfg_q[win_ch][CFG_WRITE]) begin
                    state_d = S_RACC;
                end else begin
                    state_d = S_TACC;
                end
            end
            S_RACC, S_TACC: begin
                if (!fin_now) begin
                    state_d = in_racc ? S_TACC : S_RACC;
                end else if (ended && a_auto) begin
                    // R7 reload while still bus master
                    state_d = S_RELOAD;
                end else if (ended || dropped) begin
                    // R3 finish transfer then release
                    // R6 release one state after drop
                    state_d = idle_need ? S_IDLE2 : S_REL;
                end else begin
                    // R1 demand keeps running
                    state_d = first_acc ? S_RACC : S_TACC;
                end
            end
            S_IDLE2, S_RELOAD: begin
                if (tmr_zero) begin
                    state_d = S_REL;
                end
            end
            S_REL: begin
                if (!bus_hold_acknowledge) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // Sequencer state, hold and timers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            hold_q  <= 1'b0;
            tmr_q   <= '0;
            act_q   <= 3'h0;
            end_q   <= 1'b0;
            drop_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_q  <= (state_d != S_IDLE) && (state_d != S_REL);
            if (state_q == S_ARB && win_valid) begin
                act_q <= win_ch;
            end
            if (in_racc) begin
                end_q  <= tc_now || !end_of_process_n;
                drop_q <= !req_now;
            end
            // R8 two idle states before release
            if (state_d == S_IDLE2 && state_q != S_IDLE2) begin
                tmr_q <= TMR_W'(IDLE_CYC - 1);
            end else if (state_d == S_RELOAD && state_q != S_RELOAD) begin
                tmr_q <= TMR_W'(RELOAD_CYC - 1);
            end else if (!tmr_zero) begin
                tmr_q <= tmr_q - 1'b1;
            end
        end
    end

    // Priority mode and pointers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            // R11 default fixed order
            mode_q    <= MODE_RST;
            prog_lo_q <= LO_LOWEST_RST;
            cur_lo_q  <= LO_LOWEST_RST;
            prog_up_q <= UP_LOWEST_RST;
            cur_up_q  <= UP_LOWEST_RST;
        end else begin
            if (state_q == S_ARB && win_valid) begin
                // R16 serviced channel becomes lowest
                // R17 lower service rotates upper slot
                if (win_lo && mode_q[MODE_LO_ROT]) begin
                    cur_lo_q <= lo_pick[1:0];
                end
                if (mode_q[MODE_UP_ROT]) begin
                    cur_up_q <= up_pick[2:0];
                end
            end
            // R10 independent group modes
            if (wr_mode) begin
                mode_q <= reg_wdata[1:0];
                // R15 fixed to rotating keeps order
                if (reg_wdata[MODE_LO_ROT] && !mode_q[MODE_LO_ROT]) begin
                    cur_lo_q <= prog_lo_q;
                end
                if (reg_wdata[MODE_UP_ROT] && !mode_q[MODE_UP_ROT]) begin
                    cur_up_q <= prog_up_q;
                end
            end
            // R14 command only in fixed mode
            if (wr_prio && !reg_wdata[PRIO_GRP] && !mode_q[MODE_LO_ROT]) begin
                prog_lo_q <= reg_wdata[1:0];
            end
            if (wr_prio && reg_wdata[PRIO_GRP] && !mode_q[MODE_UP_ROT]) begin
                prog_up_q <= {1'b0, reg_wdata[1:0]};
            end
        end
    end

    // Channel configuration and counts
    wire hw_end = fin_now && ended;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            chsel_q <= 3'h0;
            done_q  <= '0;
            for (int i = 0; i < NCH; i++) begin
                cfg_q[i]  <= CFG_RST;
                base_q[i] <= '0;
                cnt_q[i]  <= '0;
            end
        end else begin
            // R3 count kept across release
            if (in_racc && !tc_now) begin
                cnt_q[act_q] <= cnt_q[act_q] - 1'b1;
            end
            if (state_q == S_RELOAD && tmr_zero) begin
                cnt_q[act_q] <= base_q[act_q];
            end
            if (hw_end && !a_auto) begin
                cfg_q[act_q][CFG_EN] <= 1'b0;
            end
            // Done flags: set wins over clear
            done_q <= (done_q & ~(wr_stat ? reg_wdata[STAT_DONE +: NCH] : '0))
                    | (hw_end ? NCH'(1) << act_q : '0);
            if (wr_chsel) begin
                chsel_q <= reg_wdata[2:0];
            end
            if (wr_chcfg) begin
                cfg_q[chsel_q] <= reg_wdata[7:0];
            end
            if (wr_count) begin
                base_q[chsel_q] <= CNT_W'(reg_wdata);
                cnt_q[chsel_q]  <= CNT_W'(reg_wdata);
            end
        end
    end

    // Read mux
    wire [DATA_W-1:0] stat_word = {done_q, 1'b0, act_q, state_q};
    wire [DATA_W-1:0] rd_sel =
        (reg_addr == REG_MODE)  ? DATA_W'(mode_q) :
        (reg_addr == REG_PRIO)  ? DATA_W'({prog_up_q, 1'b0, prog_lo_q}) :
        (reg_addr == REG_STAT)  ? stat_word :
        (reg_addr == REG_CHSEL) ? DATA_W'(chsel_q) :
        (reg_addr == REG_CHCFG) ? DATA_W'(cfg_q[chsel_q]) :
        (reg_addr == REG_COUNT) ? DATA_W'(cnt_q[chsel_q]) : '0;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd ? rd_sel : '0;
        end
    end

    assign reg_rdata        = rdata_q;
    assign bus_hold_request = hold_q;
    assign requester_access = in_racc;
    assign target_access    = (state_q == S_TACC) || (in_racc && a_flyby);
    assign channel_ack      = in_racc ? (NCH'(1) << act_q) : '0;
    assign cycle_flyby      = a_flyby;
    assign cycle_write      = a_write;
    assign requester_width  = act_cfg[CFG_RW_LSB +: 2];
    assign target_width     = act_cfg[CFG_TW_LSB +: 2];

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    wire fast_drop = fin_now && in_racc && dropped && !ended && !idle_need;

    a_hold_after_req: assert property ((state_q == S_IDLE) && (|pend) |=> bus_hold_request) // R19
        else $error("hold request not raised one state after request");
    a_arb_after_ack: assert property ((state_q == S_HOLD) && bus_hold_acknowledge |=> state_q == S_ARB) // R20
        else $error("no arbitration after acknowledge");
    a_first_access: assert property ((state_q == S_HOLD) && bus_hold_acknowledge && (|pend)
        |-> ##2 (requester_access || target_access)) // R5
        else $error("first access not two states after acknowledge");
    a_release_one: assert property (fast_drop |=> !bus_hold_request) // R6
        else $error("bus not released one state after drop");
    a_reload_seven: assert property ($rose(state_q == S_RELOAD)
        |-> (bus_hold_request && state_q == S_RELOAD)[*7] ##1 state_q == S_REL) // R7
        else $error("reload not seven states");
    a_idle_two: assert property ($rose(state_q == S_IDLE2)
        |-> (bus_hold_request && state_q == S_IDLE2)[*2] ##1 !bus_hold_request) // R8
        else $error("idle states not two before release");
    a_default_fixed: assert property ((state_q == S_ARB) && (mode_q == MODE_RST) && (prog_lo_q == LO_LOWEST_RST)
        && (prog_up_q == UP_LOWEST_RST) && pend[0] |=> act_q == 3'h0) // R11
        else $error("channel 0 not granted first by default");
    a_rotate_lowest: assert property ((state_q == S_ARB) && win_valid && win_lo && mode_q[MODE_LO_ROT] && !wr_mode
        |=> cur_lo_q == $past(lo_pick[1:0])) // R16
        else $error("serviced channel not made lowest");
    a_prio_ignored: assert property (wr_prio && !reg_wdata[PRIO_GRP] && mode_q[MODE_LO_ROT]
        |=> prog_lo_q == $past(prog_lo_q)) // R14
        else $error("priority command taken while rotating");

    c_reload: cover property ($rose(state_q == S_RELOAD));
    c_idle_two: cover property ($rose(state_q == S_IDLE2));
    c_lower_rotates_upper: cover property ((state_q == S_ARB) && win_lo && (&mode_q));
    c_demand_resume: cover property (fast_drop ##[1:40] (state_q == S_ARB));

endmodule

`default_nettype wire

// ### hdl/dmapri_pkg.sv
// Constants, register map and state codes for the demand-mode DMA sequencer
// and its eight-channel priority arbiter.
// Assumes one 100 MHz bus clock, where one bus state is one clock cycle.
package dmapri_pkg;

    // Clock and bus state timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int BUS_STATE_NS       = 10;
    localparam int STATE_CYC          = (BUS_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_TO_ACC_STATES = 2;
    localparam int RELEASE_STATES     = 1;
    localparam int RELOAD_STATES      = 7;
    localparam int IDLE_STATES        = 2;
    localparam int RELOAD_CYC         = RELOAD_STATES * STATE_CYC;
    localparam int IDLE_CYC           = IDLE_STATES * STATE_CYC;

    // Widths
    localparam int NCH    = 8;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int TMR_W  = 4;

    // Register indices
    localparam logic [ADDR_W-1:0] REG_MODE  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PRIO  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STAT  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CHSEL = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CHCFG = 4'h4;
    localparam logic [ADDR_W-1:0] REG_COUNT = 4'h5;

    // Field positions
    localparam int MODE_LO_ROT = 0;
    localparam int MODE_UP_ROT = 1;
    localparam int PRIO_GRP    = 2;
    localparam int CFG_EN      = 0;
    localparam int CFG_FLYBY   = 1;
    localparam int CFG_WRITE   = 2;
    localparam int CFG_AUTO    = 3;
    localparam int CFG_RW_LSB  = 4;
    localparam int CFG_TW_LSB  = 6;
    localparam int STAT_DONE   = 8;

    // Reset values
    localparam logic [1:0] MODE_RST      = 2'h0;
    localparam logic [1:0] LO_LOWEST_RST = 2'h3;
    localparam logic [2:0] UP_LOWEST_RST = 3'h3;
    localparam logic [7:0] CFG_RST       = 8'h00;
    localparam logic [2:0] LO_SLOT       = 3'h4;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,
        S_HOLD   = 4'b0001,
        S_ARB    = 4'b0010,
        S_RACC   = 4'b0011,
        S_TACC   = 4'b0100,
        S_IDLE2  = 4'b0101,
        S_RELOAD = 4'b0110,
        S_REL    = 4'b0111
    } dmapri_state_t;

endpackage

// ### tb/dma_demand_mode_and_channel_priority_tb_top.sv
// Self-checking bench for the demand-mode sequencer and priority arbiter.
// Assumes dmapri_pkg, dmapri_core and dmapri_host_model compiled first.
`timescale 1ns/1ps
`default_nettype none

module dma_demand_mode_and_channel_priority_tb_top;
    import dmapri_pkg::*;
    logic                sys_clk  = 1'b0;
    logic                nrst     = 1'b0;
    logic [ADDR_W-1:0]   reg_addr = '0;
    logic [DATA_W-1:0]   reg_wdata = '0;
    logic                reg_wr   = 1'b0;
    logic                reg_rd   = 1'b0;
    logic [NCH-1:0]      req      = '0;
    logic [1:0]          dly      = 2'h0;
    logic                eop_n    = 1'b1;
    wire  [DATA_W-1:0]   reg_rdata;
    wire                 ack, hold, racc, tacc, fly, wrc;
    wire  [1:0]          rw, tw;
    wire  [NCH-1:0]      chack;
    int                  miscompares, tests_run, cyc, ch, k;
    int                  cur_lo = 3, cur_up = 3, prog_lo = 3, prog_up = 3;
    int                  cnt[8];
    int                  seed = 32'h839a_1ca3;
    bit                  rot_lo, rot_up;
    logic [15:0]         v, op;
    logic [7:0]          m;

    dmapri_core dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_service_request(req),
        .end_of_process_n(eop_n), .bus_hold_acknowledge(ack), .bus_hold_request(hold),
        .channel_ack(chack), .requester_access(racc), .target_access(tacc), .cycle_flyby(fly),
        .cycle_write(wrc), .requester_width(rw), .target_width(tw));
    dmapri_host_model host (.sys_clk(sys_clk), .nrst(nrst), .bus_hold_request(hold),
        .ack_delay(dly), .bus_hold_acknowledge(ack));

    always #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_sim;
        end
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic setup(input int c, input logic [7:0] cfg, input int n);
        wr(REG_CHSEL, 16'(c));
        wr(REG_CHCFG, {8'h00, cfg});
        wr(REG_COUNT, 16'(n));
        cnt[c] = n;
        rd(REG_CHCFG, v);
        chk(v, {8'h00, cfg}, "config readback");
    endtask

    function automatic int winner(input logic [7:0] mk);
        int s, c;
        for (int i = 1; i <= 5; i++) begin
            s = (cur_up + i) % 5;
            if (s == 4) begin
                for (int j = 1; j <= 4; j++) begin
                    c = (cur_lo + j) % 4;
                    if (mk[c]) return c;
                end
            end else if (mk[4 + s]) return 4 + s;
        end
        return 0;
    endfunction

    // Raise requests, check hold and access timing and the granted channel
    task automatic start(input logic [7:0] mk, output int c);
        int t_ack;
        t_ack = -1;
        c = winner(mk);
        @(posedge sys_clk);
        req <= mk;
        @(posedge sys_clk);
        #1 chk(16'(hold), 16'h0001, "hold late");
        for (k = 0; k < 40 && !racc; k++) begin
            if (ack && t_ack < 0) t_ack = k;
            @(posedge sys_clk);
            #1;
        end
        chk(16'(k - t_ack), 16'h0002, "ack to access");
        chk(16'(chack), 16'(1 << c), "grant");
        if (rot_lo && c < 4) cur_lo = c;
        if (rot_up) cur_up = (c < 4) ? 4 : c - 4;
    endtask

    // Count hold-high cycles after the last requester access
    task automatic tail(input int exp, input string name);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        while (hold && n < 20) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk(16'(n), 16'(exp), "release tail");
        for (k = 0; k < 10 && ack; k++) @(posedge sys_clk);
        @(posedge sys_clk);
        $display("test %s done", name);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(REG_MODE, v);
        chk(v, 16'h0000, "mode reset");
        rd(REG_PRIO, v);
        chk(v, 16'h001b, "prio reset");
        wr(4'hf, 16'hffff);
        rd(4'hf, v);
        chk(v, 16'h0000, "unmapped");
        // Auto-init fly-by, expiry on second access
        setup(0, 8'h0b, 1);
        start(8'h01, ch);
        @(posedge sys_clk) req <= '0;
        #1 chk(16'(racc), 16'h0001, "second access");
        tail(7, "auto_init");
        rd(REG_COUNT, v);
        chk(v, 16'h0001, "reload count");
        // Two-cycle write, request dropped mid-run
        setup(1, 8'hb5, 10);
        start(8'h02, ch);
        chk({10'h0, tw, rw, fly, wrc}, 16'h002d, "cycle kind");
        @(posedge sys_clk) req <= '0;
        #1 chk(16'(tacc), 16'h0001, "target access");
        @(posedge sys_clk);
        #1 chk(16'(racc), 16'h0001, "last requester");
        tail(3, "two_cycle");
        // Clear the done flag left by the auto-init run
        wr(REG_STAT, 16'hff00);
        // Single-buffer expiry with request held high
        setup(2, 8'h03, 2);
        start(8'h04, ch);
        repeat (2) begin
            @(posedge sys_clk);
            #1 chk(16'(racc), 16'h0001, "held access");
        end
        tail(0, "expiry");
        repeat (4) @(posedge sys_clk);
        #1 chk(16'(hold), 16'h0000, "disabled channel");
        @(posedge sys_clk) req <= '0;
        // End-of-process input ends a held demand run
        setup(3, 8'h03, 100);
        start(8'h08, ch);
        @(posedge sys_clk) eop_n <= 1'b0;
        #1 chk(16'(racc), 16'h0001, "eop access");
        @(posedge sys_clk) eop_n <= 1'b1;
        req <= '0;
        tail(0, "eop");
        rd(REG_STAT, v);
        chk({8'h0, v[15:8]}, 16'h000c, "done flag");
        // Random priority commands, mode switches and demand bursts
        for (int c = 0; c < 8; c++) setup(c, 8'h03, 512);
        repeat (40) begin
            op = 16'($random(seed));
            if (op[0]) begin
                wr(REG_MODE, {14'h0, op[2:1]});
                rot_lo = op[1];
                rot_up = op[2];
                if (!rot_lo) cur_lo = prog_lo;
                if (!rot_up) cur_up = prog_up;
            end
            if (op[3]) begin
                wr(REG_PRIO, {13'h0, op[6:4]});
                if (op[6] && !rot_up) begin
                    prog_up = op[5:4];
                    cur_up  = prog_up;
                end
                if (!op[6] && !rot_lo) begin
                    prog_lo = op[5:4];
                    cur_lo  = prog_lo;
                end
                rd(REG_PRIO, v);
                chk(v, 16'({3'(prog_up), 1'b0, 2'(prog_lo)}), "prio command");
            end
            m = 8'($random(seed));
            if (m == 8'h00) m = 8'h01;
            dly <= 2'($random(seed));
            start(m, ch);
            @(posedge sys_clk) req <= '0;
            #1 chk(16'(racc), 16'h0001, "sampled access");
            tail(0, "burst");
            cnt[ch] -= 2;
            wr(REG_CHSEL, 16'(ch));
            rd(REG_COUNT, v);
            chk(v, 16'(cnt[ch]), "saved count");
        end
        end_sim;
    end
endmodule

`default_nettype wire

// ### tb/dmapri_host_model.sv
// Host side of the bus hold handshake, answering after a chosen delay.
// Assumes the DMA block drives the hold request from the same clock.
`timescale 1ns/1ps
`default_nettype none

module dmapri_host_model (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       bus_hold_request,
    input  wire logic [1:0] ack_delay,
    output logic            bus_hold_acknowledge
);
    logic [1:0] wait_q;

    // Grant ack_delay+1 cycles after request, withdraw one cycle after release
    always_ff @(posedge sys_clk) begin
        if (!nrst || !bus_hold_request) begin
            bus_hold_acknowledge <= 1'b0;
            wait_q               <= 2'h0;
        end else if (!bus_hold_acknowledge) begin
            if (wait_q == ack_delay) begin
                bus_hold_acknowledge <= 1'b1;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

`default_nettype wire
